// ==== ctrl_block_decode.sv ====
// Control block window decode and upper/lower memory select generation
`timescale 1ns/1ps
module ctrl_block_decode
  import ctrl_block_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        cycle_start,
  input  wire logic        cycle_end,
  input  wire logic [19:0] cycle_addr,
  input  wire logic        cycle_is_mem,
  input  wire logic        cycle_is_write,
  input  wire logic        cycle_is_dma,
  input  wire logic [15:0] cycle_wdata,
  input  wire logic [1:0]  cycle_byte_en,
  input  wire logic [15:0] ext_data_in,
  input  wire logic        sync_ready_in,
  input  wire logic        async_ready_in,
  output logic [15:0]      reg_rdata,
  output logic             internal_hit,
  output logic             take_ext_data,
  output logic             take_ext_ready,
  output logic             top_memory_select_n,
  output logic             bottom_memory_select_n,
  output logic [2:0]       ready_mode_bits,
  output logic             ready_mode_valid,
  output logic             slave_interrupt_mode,
  output logic             escape_instruction_trap,
  output logic [15:0]      data_to_core,
  output logic             ready_to_core
);

  // ==========================================================================
  // Pin synchronisers for the ready inputs
  logic sr_meta_q, sr_sync_q, ar_meta_q, ar_sync_q;
  logic sr_meta_d, sr_sync_d, ar_meta_d, ar_sync_d;

  // Next values of the synchroniser chain
  always_comb begin
    sr_meta_d = sync_ready_in;
    sr_sync_d = sr_meta_q;
    ar_meta_d = async_ready_in;
    ar_sync_d = ar_meta_q;
  end

  // Register the synchroniser chain
  always_ff @(posedge clk) begin
    if (srst) begin
      sr_meta_q <= 1'b0;
      sr_sync_q <= 1'b0;
      ar_meta_q <= 1'b0;
      ar_sync_q <= 1'b0;
    end else begin
      sr_meta_q <= sr_meta_d;
      sr_sync_q <= sr_sync_d;
      ar_meta_q <= ar_meta_d;
      ar_sync_q <= ar_sync_d;
    end
  end

  // ==========================================================================
  // Register file state
  logic [15:0] reloc_q, reloc_d;
  logic [15:0] top_q, top_d;
  logic [15:0] bottom_q, bottom_d;
  logic        bottom_armed_q, bottom_armed_d;
  bus_phase_e  phase_q, phase_d;

  // Latched cycle attributes held for the whole bus cycle
  logic [19:0] addr_q, addr_d;
  logic        mem_q, mem_d;
  logic        win_q, win_d;

  // Window decode and region compare wires
  logic        win_space_ok;
  logic        win_base_ok;
  logic        win_now;
  logic        top_hit;
  logic        bottom_hit;
  logic [7:0]  win_off;
  logic [15:0] rd_mux;

  // Window hit for the presented address
  always_comb begin
    win_space_ok = (cycle_is_mem == reloc_q[RELOC_MEM_BIT]);
    // Base is relocation bits 11:0 as address bits 19:8, low byte zero
    if (cycle_is_mem) begin
      win_base_ok = (cycle_addr[19:8] == reloc_q[RELOC_BASE_W-1:RELOC_BASE_LSB]);
    end else begin
      // I/O space is 16 bits wide, address bits 19:16 expected zero
      win_base_ok = (cycle_addr[15:8] == reloc_q[7:0]) && (cycle_addr[19:16] == 4'h0);
    end
    win_now = win_space_ok && win_base_ok;
    win_off = addr_q[7:0];
  end

  // Region comparators on the latched address
  limit_compare u_cmp (
    .addr         (addr_q),
    .top_limit    (top_q),
    .bottom_limit (bottom_q),
    .bottom_armed (bottom_armed_q),
    .top_hit      (top_hit),
    .bottom_hit   (bottom_hit)
  );

  // ==========================================================================
  // Bus cycle tracking and register write logic
  always_comb begin
    phase_d        = phase_q;
    addr_d         = addr_q;
    mem_d          = mem_q;
    win_d          = win_q;
    reloc_d        = reloc_q;
    top_d          = top_q;
    bottom_d       = bottom_q;
    bottom_armed_d = bottom_armed_q;
    unique case (phase_q)
      PH_IDLE: begin
        if (cycle_start) begin
          // CPU and DMA cycles are latched the same way
          addr_d  = cycle_addr;
          mem_d   = cycle_is_mem;
          win_d   = win_now;
          phase_d = PH_ADDR;
        end
      end
      PH_ADDR: begin
        phase_d = PH_DATA;
      end
      PH_DATA: begin
        if (cycle_end) begin
          phase_d = PH_IDLE;
          win_d   = 1'b0;
          if (win_q && cycle_is_write) begin
            // Word registers with byte lanes
            unique case (win_off)
              OFF_RELOCATION: begin
                if (cycle_byte_en[0]) reloc_d[7:0]  = cycle_wdata[7:0];
                if (cycle_byte_en[1]) reloc_d[15:8] = cycle_wdata[15:8];
              end
              OFF_TOP_REGION: begin
                if (cycle_byte_en[0]) top_d[7:0]  = cycle_wdata[7:0];
                if (cycle_byte_en[1]) top_d[15:8] = cycle_wdata[15:8];
              end
              OFF_BOTTOM_REGION: begin
                if (cycle_byte_en[0]) bottom_d[7:0]  = cycle_wdata[7:0];
                if (cycle_byte_en[1]) bottom_d[15:8] = cycle_wdata[15:8];
              end
              default: begin
              end
            endcase
          end
          // Any access to the bottom limit arms its select
          if (win_q && (win_off == OFF_BOTTOM_REGION)) begin
            bottom_armed_d = 1'b1;
          end
        end
      end
      default: begin
        phase_d = PH_IDLE;
      end
    endcase
  end

  // Register cycle state and registers
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_q        <= PH_IDLE;
      addr_q         <= 20'h00000;
      mem_q          <= 1'b0;
      win_q          <= 1'b0;
      reloc_q        <= RELOC_RESET;
      top_q          <= TOP_RESET;
      bottom_q       <= BOTTOM_RESET;
      bottom_armed_q <= 1'b0;
    end else begin
      phase_q        <= phase_d;
      addr_q         <= addr_d;
      mem_q          <= mem_d;
      win_q          <= win_d;
      reloc_q        <= reloc_d;
      top_q          <= top_d;
      bottom_q       <= bottom_d;
      bottom_armed_q <= bottom_armed_d;
    end
  end

  // ==========================================================================
  // Output stage: all outputs registered
  logic [15:0] rdata_q, rdata_d;
  logic        hit_q, hit_d, tdat_q, tdat_d, trdy_q, trdy_d;
  logic        top_n_q, top_n_d, bot_n_q, bot_n_d;
  logic [2:0]  mode_q, mode_d;
  logic        mode_v_q, mode_v_d;
  logic [15:0] core_data_q, core_data_d;
  logic        core_rdy_q, core_rdy_d;
  logic        in_cycle;

  // Read mux and select generation
  always_comb begin
    unique case (win_off)
      OFF_RELOCATION:    rd_mux = reloc_q;
      OFF_TOP_REGION:    rd_mux = top_q;
      OFF_BOTTOM_REGION: rd_mux = bottom_q;
      default:           rd_mux = 16'h0000;
    endcase
    in_cycle = (phase_q != PH_IDLE);
    rdata_d  = win_q ? rd_mux : 16'h0000;
    hit_d    = in_cycle && win_q;
    // Window cycles ignore external data and both ready inputs
    tdat_d   = in_cycle && !win_q;
    trdy_d   = in_cycle && !win_q;
    // Active-low selects held for the whole memory cycle
    top_n_d  = !(in_cycle && mem_q && top_hit);
    bot_n_d  = !(in_cycle && mem_q && bottom_hit);
    // Ready mode of the hit region
    if (in_cycle && mem_q && top_hit) begin
      mode_d   = top_q[READY_MODE_W-1:0];
      mode_v_d = 1'b1;
    end else if (in_cycle && mem_q && bottom_hit) begin
      mode_d   = bottom_q[READY_MODE_W-1:0];
      mode_v_d = 1'b1;
    end else begin
      mode_d   = 3'h0;
      mode_v_d = 1'b0;
    end
    // Data and ready toward the core; window answers internally
    if (win_q) begin
      core_data_d = rd_mux;
      core_rdy_d  = in_cycle;
    end else begin
      core_data_d = ext_data_in;
      core_rdy_d  = in_cycle && (sr_sync_q || ar_sync_q);
    end
  end

  // Register the outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q     <= 16'h0000;
      hit_q       <= 1'b0;
      tdat_q      <= 1'b0;
      trdy_q      <= 1'b0;
      top_n_q     <= 1'b1;
      bot_n_q     <= 1'b1;
      mode_q      <= 3'h0;
      mode_v_q    <= 1'b0;
      core_data_q <= 16'h0000;
      core_rdy_q  <= 1'b0;
    end else begin
      rdata_q     <= rdata_d;
      hit_q       <= hit_d;
      tdat_q      <= tdat_d;
      trdy_q      <= trdy_d;
      top_n_q     <= top_n_d;
      bot_n_q     <= bot_n_d;
      mode_q      <= mode_d;
      mode_v_q    <= mode_v_d;
      core_data_q <= core_data_d;
      core_rdy_q  <= core_rdy_d;
    end
  end

  // Drive ports from flip-flops
  assign reg_rdata               = rdata_q;
  assign internal_hit            = hit_q;
  assign take_ext_data           = tdat_q;
  assign take_ext_ready          = trdy_q;
  assign top_memory_select_n     = top_n_q;
  assign bottom_memory_select_n  = bot_n_q;
  assign ready_mode_bits         = mode_q;
  assign ready_mode_valid        = mode_v_q;
  assign slave_interrupt_mode    = reloc_q[RELOC_SLAVE_BIT];
  assign escape_instruction_trap = reloc_q[RELOC_TRAP_BIT];
  assign data_to_core            = core_data_q;
  assign ready_to_core           = core_rdy_q;

endmodule

// ==== ctrl_block_pkg.sv ====
// Constants for the control block window and memory select decode
package ctrl_block_pkg;

  // ==========================================================================
  // Window geometry and register offsets
  localparam int unsigned    WINDOW_BYTES      = 256;
  localparam logic [7:0]     OFF_TOP_REGION    = 8'ha0;
  localparam logic [7:0]     OFF_BOTTOM_REGION = 8'ha2;
  localparam logic [7:0]     OFF_RELOCATION    = 8'hfe;

  // ==========================================================================
  // Reset values
  localparam logic [15:0]    RELOC_RESET       = 16'h20ff;
  localparam logic [15:0]    TOP_RESET         = 16'hfff8;
  localparam logic [15:0]    BOTTOM_RESET      = 16'h0000;

  // ==========================================================================
  // Relocation register fields
  localparam int unsigned    RELOC_MEM_BIT     = 12;
  localparam int unsigned    RELOC_SLAVE_BIT   = 14;
  localparam int unsigned    RELOC_TRAP_BIT    = 13;
  localparam int unsigned    RELOC_BASE_LSB    = 0;
  localparam int unsigned    RELOC_BASE_W      = 12;

  // ==========================================================================
  // Limit register fields
  localparam int unsigned    LIMIT_LOW_BITS    = 6;
  localparam int unsigned    READY_MODE_W      = 3;

  // ==========================================================================
  // Bus cycle phases
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b11
  } bus_phase_e;

endpackage

// ==== limit_compare.sv ====
// Upper and lower memory region comparators
`timescale 1ns/1ps
module limit_compare
  import ctrl_block_pkg::*;
(
  input  wire logic [19:0] addr,
  input  wire logic [15:0] top_limit,
  input  wire logic [15:0] bottom_limit,
  input  wire logic        bottom_armed,
  output logic             top_hit,
  output logic             bottom_hit
);

  logic [15:0] top_floor;
  logic [15:0] bottom_ceiling;

  // Force the low limit bits to zero or one before comparing
  always_comb begin
    top_floor      = {top_limit[15:LIMIT_LOW_BITS], {LIMIT_LOW_BITS{1'b0}}};
    bottom_ceiling = {bottom_limit[15:LIMIT_LOW_BITS], {LIMIT_LOW_BITS{1'b1}}};
    top_hit        = (addr[19:4] >= top_floor);
    bottom_hit     = bottom_armed && (addr[19:4] <= bottom_ceiling);
  end

endmodule

// ==== ctrl_block_checker_assertions.sv ====
// Port-level checker for the window decode and memory selects
`timescale 1ns/1ps
module ctrl_block_checker
  import ctrl_block_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        cycle_start,
  input wire logic        cycle_end,
  input wire logic [19:0] cycle_addr,
  input wire logic        cycle_is_mem,
  input wire logic [15:0] ext_data_in,
  input wire logic [15:0] reg_rdata,
  input wire logic        internal_hit,
  input wire logic        take_ext_data,
  input wire logic        take_ext_ready,
  input wire logic        top_memory_select_n,
  input wire logic        bottom_memory_select_n,
  input wire logic        slave_interrupt_mode,
  input wire logic        escape_instruction_trap,
  input wire logic [15:0] data_to_core,
  input wire logic        ready_mode_valid,
  input wire logic        ready_to_core
);
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  chk_hit_blocks_ext: assert property (internal_hit |-> !take_ext_data && !take_ext_ready)
    else $error("external inputs taken in a window cycle");
  chk_io_no_select: assert property (cycle_start && !cycle_is_mem |->
    ##3 top_memory_select_n && bottom_memory_select_n) else $error("select on I/O cycle");
  chk_top_high_addr: assert property (cycle_start && cycle_is_mem &&
    cycle_addr[19:10] == 10'h3ff |-> ##3 !top_memory_select_n) else $error("top select missing");
  chk_one_select: assert property (top_memory_select_n || bottom_memory_select_n)
    else $error("two selects active");
  chk_select_stands: assert property ($fell(top_memory_select_n) |=> !top_memory_select_n)
    else $error("top select dropped early");
  chk_end_releases: assert property (internal_hit && cycle_end |-> ##[1:3] !internal_hit)
    else $error("window cycle not released");
  chk_rdata_idle: assert property (!internal_hit |-> reg_rdata == 16'h0000)
    else $error("read data outside window cycle");
  chk_window_data: assert property (internal_hit |-> data_to_core == reg_rdata)
    else $error("core data not from window");
  chk_window_ready: assert property (internal_hit |-> ready_to_core)
    else $error("window cycle not answered internally");
  chk_mode_valid: assert property (!(top_memory_select_n && bottom_memory_select_n) |->
    ready_mode_valid) else $error("ready mode not flagged for a selected region");
  chk_ext_data: assert property ($past(take_ext_data) |-> data_to_core == $past(ext_data_in))
    else $error("core data not from external bus");
  chk_reset_reloc: assert property ($fell(srst) |->
    escape_instruction_trap && !slave_interrupt_mode)
    else $error("relocation mode bits wrong after reset");
  // Main scenarios reached
  cov_top: cover property ($fell(top_memory_select_n));
  cov_bottom: cover property ($fell(bottom_memory_select_n));
  cov_window: cover property ($rose(internal_hit));
endmodule
bind ctrl_block_decode ctrl_block_checker chk (.*);

// ==== ext_bus_model.sv ====
// Far side model: external data and ready pins seen by the decoder
`timescale 1ns/1ps
module ext_bus_model (
  input  wire logic   clk,
  output logic [15:0] ext_data_in,
  output logic        sync_ready_in,
  output logic        async_ready_in
);
  // ==========================================================================
  // Data changes every cycle so window cycles can never pick it up by chance
  // Ready pins stay low, so only the internal answer can raise ready to the core
  initial begin
    ext_data_in = 16'h5a5a;
    sync_ready_in = 1'b0;
    async_ready_in = 1'b0;
  end
  always @(negedge clk) begin
    ext_data_in <= ~ext_data_in + 16'h0013;
  end
endmodule

// ==== test_control_block_and_memory_select_decode.sv ====
// Directed bench for the window decode and memory selects
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_control_block_and_memory_select_decode;
  import ctrl_block_pkg::*;
  logic clk = 0, srst = 1, cycle_start = 0, cycle_end = 0, cycle_is_mem = 0;
  logic cycle_is_write = 0, cycle_is_dma = 0;
  logic [19:0] cycle_addr = 20'h00000;
  logic [15:0] cycle_wdata = 16'h0000, reg_rdata, data_to_core, r_data, ext_data_in;
  logic [1:0] cycle_byte_en = 2'b00;
  logic [2:0] ready_mode_bits, r_mode;
  logic sync_ready_in, async_ready_in, internal_hit, take_ext_data, take_ext_ready;
  logic top_memory_select_n, bottom_memory_select_n, ready_mode_valid, ready_to_core;
  logic slave_interrupt_mode, escape_instruction_trap, r_top, r_bot, r_hit, r_mv, r_rdy;
  int n_mismatch = 0, n_compared = 0, cycles = 0;
  ctrl_block_decode dut (.*);
  ext_bus_model partner (.*);
  always #2.5 clk = ~clk;
  // ==========================================================================
  // Verdict and hang guard
  task automatic end_of_test();
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ==========================================================================
  // One bus cycle: start, sample at the answer, end in the data phase
  task automatic cyc(input logic [19:0] a, input logic m, w, input logic [15:0] d,
                     input logic [1:0] be);
    @(negedge clk);
    cycle_start = 1;
    cycle_addr = a;
    cycle_is_mem = m;
    cycle_is_write = w;
    cycle_wdata = d;
    cycle_byte_en = be;
    @(negedge clk);
    cycle_start = 0;
    repeat (2) @(negedge clk);
    {r_data, r_top, r_bot, r_hit, r_mode, r_mv, r_rdy} = {reg_rdata, top_memory_select_n,
      bottom_memory_select_n, internal_hit, ready_mode_bits, ready_mode_valid, ready_to_core};
    cycle_end = 1;
    @(negedge clk);
    cycle_end = 0;
  endtask
  task automatic rd(input logic [19:0] a, input logic m, input logic [15:0] e);
    cyc(a, m, 0, 16'h0000, 2'b00);
    `CHK({r_hit, r_rdy, r_data}, {2'b11, e})
  endtask
  task automatic sel(input logic [19:0] a, input logic t, b);
    cyc(a, 1, 0, 16'h0000, 2'b00);
    `CHK({r_hit, r_top, r_bot, r_rdy, r_mv}, {1'b0, t, b, 1'b0, !(t && b)})
  endtask
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (16) @(negedge clk);
    srst = 0;
    rd(20'h0fffe, 0, RELOC_RESET);
    rd(20'h0ffa0, 0, 16'hfff8);
    `CHK({slave_interrupt_mode, escape_instruction_trap}, 2'b01)
    sel(20'hffc00, 0, 1);
    sel(20'hffbff, 1, 1);
    sel(20'h00000, 1, 1);
    cyc(20'h0ffa2, 0, 1, 16'h007b, 2'b11);
    sel(20'h007ff, 1, 0);
    `CHK(r_mode, 3'h3)
    sel(20'h00800, 1, 1);
    cyc(20'h0ffa0, 0, 1, 16'he03d, 2'b11);
    cycle_is_dma = 1;
    sel(20'he0000, 0, 1);
    `CHK(r_mode, 3'h5)
    cycle_is_dma = 0;
    sel(20'hdffff, 1, 1);
    cyc(20'h0ffa2, 0, 1, 16'hff38, 2'b01);
    rd(20'h0ffa2, 0, 16'h0038);
    rd(20'h0ff10, 0, 16'h0000);
    cyc(20'h0fffe, 0, 1, 16'h5080, 2'b11);
    `CHK({slave_interrupt_mode, escape_instruction_trap}, 2'b10)
    rd(20'h080fe, 1, 16'h5080);
    cyc(20'h0fffe, 0, 0, 16'h0000, 2'b00);
    `CHK(r_hit, 1'b0)
    cyc(20'h08100, 1, 0, 16'h0000, 2'b00);
    `CHK(r_hit, 1'b0)
    cyc(20'h080fe, 1, 1, 16'h20ff, 2'b11);
    rd(20'h0fffe, 0, 16'h20ff);
    srst = 1;
    repeat (2) @(negedge clk);
    srst = 0;
    rd(20'h0fffe, 0, RELOC_RESET);
    sel(20'h00000, 1, 1);
    end_of_test();
  end
endmodule
